//--- rtl/eeprom_cmd_pkg.sv
// constants and types for the serial eeprom command front end
// assumes a single 200 MHz core clock sampling every serial pin
// ---------------------------------------------------------------
// What this block does
// - works with serial clock modes 0,0 and 1,1
// - 4096 bytes of eight bits, 32-byte pages
// - while paused, ignore all inputs except select
// - eight-bit instruction shifted in on rising clock
// - all fields shifted most significant bit first
// - first bit sampled on first rising edge
// - pause release resumes at the same bit
// - no internal write without write latch set
// - set and clear commands drive write latch
// - latch cleared at reset and after writes
// - decode set, clear latch and read status
// - decode write status, read and write array
// - read status allowed during internal write
// - status byte layout gate, protect, latch, busy
// - busy bit is one during internal write
// - latch flag mirrors latch, ignores hardware protect
// - block protect bits changed only by write-status
// - hardware protect blocks only status nonvolatile bits
// - internal write starts at select rise, 5 ms
// - 16-bit read address, top nibble ignored, wraps
// - write only if select rises at byte end
// - output changes after falling clock, released deselected
// - block protect map none, quarter, half, all
// ---------------------------------------------------------------
package eeprom_cmd_pkg;
    localparam int unsigned core_clk_mhz = 200;
    localparam int unsigned internal_write_time_us = 5000;
    localparam int unsigned write_cycles = internal_write_time_us * core_clk_mhz;
    localparam logic [7:0] cmd_write_status = 8'h01;
    localparam logic [7:0] cmd_write_array = 8'h02;
    localparam logic [7:0] cmd_read_array = 8'h03;
    localparam logic [7:0] cmd_clear_write_latch = 8'h04;
    localparam logic [7:0] cmd_read_status = 8'h05;
    localparam logic [7:0] cmd_set_write_latch = 8'h06;
    localparam int unsigned status_gate_bit = 7;
    localparam int unsigned status_bp_hi_bit = 3;
    localparam int unsigned status_bp_lo_bit = 2;
    localparam int unsigned status_latch_bit = 1;
    localparam int unsigned status_busy_bit = 0;
    localparam logic [2:0] nv_reset = 3'h0;
    localparam logic [11:0] quarter_base = 12'hc00;
    localparam logic [11:0] half_base = 12'h800;
    typedef enum logic [2:0] {
        ph_cmd = 3'b000,
        ph_addr = 3'b001,
        ph_rdata = 3'b010,
        ph_wdata = 3'b011,
        ph_sdata = 3'b100,
        ph_rstat = 3'b101,
        ph_idle = 3'b110
    } phase_t;
endpackage

//--- rtl/spi_eeprom_command_protect.sv
// serial eeprom front end: command decode, status, protection, page write
// assumes host pins are asynchronous; every pin is synchronised first
`timescale 1ns/100ps
module spi_eeprom_command_protect
    import eeprom_cmd_pkg::*;
#(
    parameter int unsigned depth = 4096,
    parameter int unsigned page_bytes = 32,
    parameter int unsigned write_time_cycles = write_cycles
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // serial pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    output logic so_o,
    output logic so_oe
);
    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [4:0] meta_q, sync_q;
    logic sck_prev_q;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= 5'h1b;
            sync_q <= 5'h1b;
            // matches the synchroniser reset so no false edge follows reset
            sck_prev_q <= 1'b1;
        end else begin
            meta_q <= {cs_n, sck, si, hold_n, wp_n};
            sync_q <= meta_q;
            sck_prev_q <= sync_q[3];
        end
    end
    wire cs_s = sync_q[4];
    wire sck_s = sync_q[3];
    wire si_s = sync_q[2];
    wire hold_s = sync_q[1];
    wire wp_s = sync_q[0];
    logic cs_prev_q;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) cs_prev_q <= 1'b1;
        else cs_prev_q <= cs_s;
    end
    wire sel = !cs_s;
    wire cs_rise = cs_s && !cs_prev_q;
    wire cs_fall = !cs_s && cs_prev_q;
    // edges only count while selected and not paused; the shift state is
    // left untouched during a pause so the transfer resumes in place
    wire active = sel && hold_s;
    wire rise = active && sck_s && !sck_prev_q;
    wire fall = active && !sck_s && sck_prev_q;

    // ---------------------------------------------------------------
    // storage and state
    // ---------------------------------------------------------------
    logic [7:0] mem [depth];
    logic [7:0] page_buf [page_bytes];
    logic [page_bytes-1:0] page_dirty_q;
    phase_t phase_q;
    logic [2:0] bit_q;
    logic [3:0] addr_bits_q;
    logic [7:0] shift_q;
    logic [15:0] addr_sr_q;
    logic [11:0] addr_q;
    logic [7:0] cmd_q;
    logic [7:0] out_q;
    logic byte_end_q;
    logic latch_q;
    logic [2:0] nv_q; // gate, bp_hi, bp_lo
    logic [2:0] nv_pend_q;
    logic busy_q;
    logic busy_is_status_q;
    logic [31:0] wtimer_q;
    logic any_data_q;

    function automatic logic blk_protected(input logic [1:0] bp, input logic [11:0] a);
        case (bp)
            2'b00: blk_protected = 1'b0;
            2'b01: blk_protected = a >= quarter_base;
            2'b10: blk_protected = a >= half_base;
            default: blk_protected = 1'b1;
        endcase
    endfunction

    wire hw_protect = !wp_s && nv_q[2];
    wire [7:0] status_byte = {nv_q[2], 3'h0, nv_q[1], nv_q[0], latch_q, busy_q};
    wire [7:0] shift_in = {shift_q[6:0], si_s};
    wire last_bit = bit_q == 3'h7;
    wire [4:0] page_idx = addr_q[4:0];
    wire [11:0] page_base = {addr_q[11:5], 5'h00};
    wire array_ok = latch_q && !blk_protected(nv_q[1:0], page_base);
    wire status_ok = latch_q && !hw_protect;
    // select rise must land right after a whole byte
    wire commit_arr = cs_rise && phase_q == ph_wdata && byte_end_q && any_data_q
                      && array_ok && !busy_q;
    wire commit_stat = cs_rise && phase_q == ph_sdata && byte_end_q && any_data_q
                      && status_ok && !busy_q;

    // ---------------------------------------------------------------
    // serial protocol
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            phase_q <= ph_idle;
            bit_q <= 3'h0;
            addr_bits_q <= 4'h0;
            shift_q <= 8'h00;
            addr_sr_q <= 16'h0000;
            addr_q <= 12'h000;
            cmd_q <= 8'h00;
            out_q <= 8'h00;
            byte_end_q <= 1'b0;
            any_data_q <= 1'b0;
            nv_pend_q <= nv_reset;
        end else if (cs_fall) begin
            phase_q <= ph_cmd;
            bit_q <= 3'h0;
            byte_end_q <= 1'b0;
            any_data_q <= 1'b0;
        end else if (rise) begin
            shift_q <= shift_in;
            bit_q <= bit_q + 3'h1;
            byte_end_q <= last_bit;
            if (last_bit) begin
                case (phase_q)
                    ph_cmd: begin
                        cmd_q <= shift_in;
                        addr_bits_q <= 4'h0;
                        case (shift_in)
                            cmd_read_array, cmd_write_array: phase_q <= ph_addr;
                            cmd_read_status: begin
                                phase_q <= ph_rstat;
                                out_q <= status_byte;
                            end
                            cmd_write_status: phase_q <= ph_sdata;
                            default: phase_q <= ph_idle;
                        endcase
                    end
                    ph_addr: begin
                        addr_sr_q <= {addr_sr_q[7:0], shift_in};
                        addr_bits_q <= addr_bits_q + 4'h1;
                        if (addr_bits_q == 4'h1) begin
                            addr_q <= {addr_sr_q[3:0], shift_in};
                            if (cmd_q == cmd_read_array) begin
                                phase_q <= ph_rdata;
                                out_q <= mem[{addr_sr_q[3:0], shift_in}];
                            end else begin
                                phase_q <= ph_wdata;
                            end
                        end
                    end
                    ph_rdata: begin
                        addr_q <= addr_q + 12'h001;
                        out_q <= mem[addr_q + 12'h001];
                    end
                    ph_wdata: begin
                        any_data_q <= 1'b1;
                        addr_q <= {addr_q[11:5], page_idx + 5'h01};
                    end
                    ph_sdata: begin
                        any_data_q <= 1'b1;
                        nv_pend_q <= {shift_in[status_gate_bit], shift_in[status_bp_hi_bit],
                                      shift_in[status_bp_lo_bit]};
                    end
                    ph_rstat: out_q <= status_byte;
                    default: phase_q <= ph_idle;
                endcase
            end
        end
    end

    // page buffer collects bytes; only a valid commit copies it out
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            page_dirty_q <= '0;
        end else if (cs_fall) begin
            page_dirty_q <= '0;
        end else if (rise && last_bit && phase_q == ph_wdata) begin
            page_dirty_q[page_idx] <= 1'b1;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rise && last_bit && phase_q == ph_wdata) page_buf[page_idx] <= shift_in;
    end
    always_ff @(posedge core_clk) begin
        if (commit_arr) begin
            for (int i = 0; i < page_bytes; i++) begin
                if (page_dirty_q[i]) mem[{page_base[11:5], 5'(i)}] <= page_buf[i];
            end
        end
    end

    // ---------------------------------------------------------------
    // latch, status and internal write timer
    // ---------------------------------------------------------------
    wire set_cmd = cs_rise && phase_q == ph_idle && cmd_q == cmd_set_write_latch
                   && byte_end_q;
    wire clr_cmd = cs_rise && phase_q == ph_idle && cmd_q == cmd_clear_write_latch
                   && byte_end_q;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            latch_q <= 1'b0;
            nv_q <= nv_reset;
            busy_q <= 1'b0;
            busy_is_status_q <= 1'b0;
            wtimer_q <= 32'h0;
        end else begin
            if (set_cmd) latch_q <= 1'b1;
            else if (clr_cmd) latch_q <= 1'b0;
            if (commit_arr || commit_stat) begin
                busy_q <= 1'b1;
                busy_is_status_q <= commit_stat;
                wtimer_q <= 32'(write_time_cycles - 1);
            end else if (busy_q) begin
                if (wtimer_q == 32'h0) begin
                    busy_q <= 1'b0;
                    // a set command landing on the last busy cycle wins
                    if (!set_cmd) latch_q <= 1'b0;
                    if (busy_is_status_q) nv_q <= nv_pend_q;
                end else begin
                    wtimer_q <= wtimer_q - 32'h1;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // serial output
    // ---------------------------------------------------------------
    wire reading = phase_q == ph_rdata || phase_q == ph_rstat;
    wire rd_allowed = phase_q == ph_rstat || !busy_q;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            so_o <= 1'b0;
            so_oe <= 1'b0;
        end else if (!sel) begin
            so_oe <= 1'b0;
        end else if (fall && reading && rd_allowed) begin
            so_oe <= 1'b1;
            so_o <= out_q[3'h7 - bit_q];
        end else if (!reading) begin
            so_oe <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    // independent count of busy cycles, so the timer itself is not trusted
    logic [31:0] busy_len_q;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            busy_len_q <= 32'h0;
        end else if (!busy_q) begin
            busy_len_q <= 32'h0;
        end else begin
            busy_len_q <= busy_len_q + 32'h1;
        end
    end
    wire cmd_known = shift_in inside {cmd_write_status, cmd_write_array,
                                      cmd_read_array, cmd_clear_write_latch,
                                      cmd_read_status, cmd_set_write_latch};

    sequence busy_start_s;
        !busy_q ##1 busy_q;
    endsequence
    sequence cmd_byte_done_s;
        rise && last_bit && phase_q == ph_cmd;
    endsequence
    sequence wdata_byte_s;
        rise && last_bit && phase_q == ph_wdata;
    endsequence
    sequence rdata_byte_s;
        rise && last_bit && phase_q == ph_rdata;
    endsequence
    chk_cmd_restart: assert property (@(posedge core_clk) disable iff (!resetn)
        cs_fall |=> phase_q == ph_cmd && bit_q == 3'h0)
        else $error("select fall did not restart the command");
    chk_unknown_ignored: assert property (@(posedge core_clk) disable iff (!resetn)
        cmd_byte_done_s ##0 !cmd_known |=> phase_q == ph_idle)
        else $error("unknown instruction not ignored");
    chk_status_cmd: assert property (@(posedge core_clk) disable iff (!resetn)
        cmd_byte_done_s ##0 (shift_in == cmd_read_status)
        |=> phase_q == ph_rstat && out_q == $past(status_byte))
        else $error("status read not started");
    chk_page_wrap: assert property (@(posedge core_clk) disable iff (!resetn)
        wdata_byte_s |=> addr_q[11:5] == $past(addr_q[11:5]))
        else $error("page write left its page");
    chk_read_step: assert property (@(posedge core_clk) disable iff (!resetn)
        rdata_byte_s |=> addr_q == $past(addr_q) + 12'h001)
        else $error("read address did not step");
    chk_so_after_fall: assert property (@(posedge core_clk) disable iff (!resetn)
        $changed(so_o) |-> $past(fall))
        else $error("output changed without a falling clock");
    chk_busy_length: assert property (@(posedge core_clk) disable iff (!resetn)
        busy_q |-> busy_len_q < 32'(write_time_cycles))
        else $error("internal write ran too long");
    chk_busy_full: assert property (@(posedge core_clk) disable iff (!resetn)
        $fell(busy_q) |-> $past(busy_len_q) == 32'(write_time_cycles - 1))
        else $error("internal write ended early");
    chk_no_read_busy: assert property (@(posedge core_clk) disable iff (!resetn)
        sel && phase_q == ph_rdata && busy_q |=> !so_oe)
        else $error("array read answered during internal write");
    chk_busy_needs_latch: assert property (@(posedge core_clk) disable iff (!resetn)
        busy_start_s |-> $past(latch_q))
        else $error("internal write started without latch");
    chk_bp_only_status: assert property (@(posedge core_clk) disable iff (!resetn)
        $changed(nv_q) |-> $past(busy_q && busy_is_status_q && wtimer_q == 32'h0))
        else $error("protect bits changed outside status write");
    chk_busy_needs_commit: assert property (@(posedge core_clk) disable iff (!resetn)
        busy_start_s |-> $past(commit_arr || commit_stat))
        else $error("busy rose without a valid commit");
    chk_commit_needs_latch: assert property (@(posedge core_clk) disable iff (!resetn)
        (commit_arr || commit_stat) |-> latch_q)
        else $error("write committed without latch");
    chk_latch_clear_end: assert property (@(posedge core_clk) disable iff (!resetn)
        ($fell(busy_q) && !$past(set_cmd)) |-> !latch_q)
        else $error("latch not cleared after write");
    chk_set_latch: assert property (@(posedge core_clk) disable iff (!resetn)
        set_cmd |=> latch_q)
        else $error("set command did not set latch");
    chk_clear_latch: assert property (@(posedge core_clk) disable iff (!resetn)
        clr_cmd |=> !latch_q)
        else $error("clear command did not clear latch");
    chk_so_released: assert property (@(posedge core_clk) disable iff (!resetn)
        !sel |=> !so_oe)
        else $error("output driven while deselected");
    chk_hold_freezes: assert property (@(posedge core_clk) disable iff (!resetn)
        (sel && !hold_s && !cs_fall) |=> $stable(bit_q) && $stable(phase_q))
        else $error("state moved during pause");
    chk_hw_protect: assert property (@(posedge core_clk) disable iff (!resetn)
        commit_stat |-> !(nv_q[2] && !wp_s))
        else $error("status write under hardware protect");
    chk_bp_stable: assert property (@(posedge core_clk) disable iff (!resetn)
        !busy_is_status_q |=> $stable(nv_q))
        else $error("protect bits changed without status write");
    chk_protected_blocked: assert property (@(posedge core_clk) disable iff (!resetn)
        commit_arr |-> !blk_protected(nv_q[1:0], page_base))
        else $error("write to protected block");
endmodule

//--- tb/host_master.sv
// host model: serial bus master driving the eeprom front end pins
// assumes the bench fills tx_q, then calls frame(); read bytes land in rx_q
`timescale 1ns/100ps
module host_master (
    // clock
    input wire logic core_clk,
    // serial pins
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic hold_n,
    input wire logic so_o,
    input wire logic so_oe
);
    logic [7:0] tx_q[$];
    logic [7:0] rx_q[$];
    logic idle_hi = 1'b0;
    int hold_bit = -1;
    logic so_last_q = 1'b0;
    // a released line shows the inverse of its last value, never a stale copy
    wire so_line = so_oe ? so_o : ~so_last_q;
    always @(posedge core_clk) if (so_oe) so_last_q <= so_o;
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
    end
    task automatic half();
        repeat (16) @(posedge core_clk);
    endtask
    task automatic bit_io(input logic b, output logic r);
        sck <= 1'b0;
        si <= b;
        half();
        if (hold_bit == 0) begin
            hold_n <= 1'b0;
            half();
            // junk edges while paused must not shift anything
            si <= ~b;
            sck <= 1'b1;
            half();
            sck <= 1'b0;
            si <= b;
            half();
            hold_n <= 1'b1;
            half();
        end
        hold_bit--;
        sck <= 1'b1;
        r = so_line;
        half();
    endtask
    task automatic frame(input int n_rd, input int cut);
        logic [7:0] b;
        logic [7:0] r;
        int nb;
        rx_q = {};
        sck <= idle_hi;
        half();
        cs_n <= 1'b0;
        half();
        nb = tx_q.size() + n_rd;
        for (int k = 0; k < nb; k++) begin
            b = (k < tx_q.size()) ? tx_q[k] : 8'h00;
            for (int i = 7; i >= 0; i--) begin
                // a cut raises select mid-byte on purpose
                if (k == nb - 1 && cut > 0 && 7 - i == cut) break;
                bit_io(b[i], r[i]);
            end
            if (k >= tx_q.size()) rx_q.push_back(r);
        end
        sck <= idle_hi;
        half();
        cs_n <= 1'b1;
        si <= ~si;
        half();
        tx_q = {};
    endtask
endmodule

//--- tb/testbench.sv
// self-checking bench for the serial eeprom command front end
// assumes host_master drives the pins; internal write shortened to 800 cycles
`timescale 1ns/100ps
module testbench;
    import eeprom_cmd_pkg::*;
    localparam int unsigned wt = 800;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic wp_n = 1'b1;
    logic cs_n, sck, si, hold_n, so_o, so_oe;
    int errors = 0;
    int samples_checked = 0;
    spi_eeprom_command_protect #(.write_time_cycles(wt)) i_spi_eeprom_command_protect (
        .core_clk(core_clk), .resetn(resetn), .cs_n(cs_n), .sck(sck), .si(si),
        .hold_n(hold_n), .wp_n(wp_n), .so_o(so_o), .so_oe(so_oe));
    host_master host (.core_clk(core_clk), .cs_n(cs_n), .sck(sck), .si(si),
        .hold_n(hold_n), .so_o(so_o), .so_oe(so_oe));
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    // ----------------------------------------
    // shared helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic send(input logic [7:0] q[$], input int cut);
        host.tx_q = q;
        host.frame(0, cut);
    endtask
    task automatic stat(input logic [7:0] exp);
        host.tx_q = {cmd_read_status};
        host.frame(1, 0);
        chk("status", exp, host.rx_q[0]);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1);
        host.tx_q = {cmd_read_array, a[15:8], a[7:0]};
        host.frame(2, 0);
        chk("read byte 0", e0, host.rx_q[0]);
        chk("read byte 1", e1, host.rx_q[1]);
    endtask
    // polls busy with a bound, so a stuck busy bit cannot hang the run
    task automatic wait_idle();
        logic [7:0] v;
        v = 8'h01;
        for (int n = 0; n < 8 && v[0] !== 1'b0; n++) begin
            host.tx_q = {cmd_read_status};
            host.frame(1, 0);
            v = host.rx_q[0];
        end
        chk("busy end", 8'h00, {7'h00, v[0]});
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_latch();
        stat(8'h00);
        send({cmd_set_write_latch}, 0);
        stat(8'h02);
        send({cmd_clear_write_latch}, 0);
        stat(8'h00);
        send({8'h07, cmd_set_write_latch}, 0);
        stat(8'h00);
        $display("test latch done, idle level %0d", host.idle_hi);
    endtask
    task automatic t_write();
        send({cmd_set_write_latch}, 0);
        send({cmd_write_array, 8'hf0, 8'h1e, 8'h11, 8'h22, 8'h33}, 0);
        stat(8'h03);
        wait_idle();
        stat(8'h00);
        send({cmd_set_write_latch}, 0);
        send({cmd_write_array, 8'h0f, 8'hff, 8'h77}, 0);
        wait_idle();
        rd(16'h001e, 8'h11, 8'h22);
        host.hold_bit = 13;
        rd(16'hffff, 8'h77, 8'h33);
        $display("test write done");
    endtask
    task automatic t_refuse();
        send({cmd_write_array, 8'h00, 8'h00, 8'h99}, 0);
        stat(8'h00);
        send({cmd_set_write_latch}, 0);
        send({cmd_write_array, 8'h00, 8'h00, 8'h99}, 4);
        stat(8'h02);
        send({cmd_clear_write_latch}, 0);
        rd(16'h0fff, 8'h77, 8'h33);
        $display("test refuse done");
    endtask
    task automatic t_protect();
        logic prot;
        for (int c = 0; c < 4; c++) begin
            send({cmd_set_write_latch}, 0);
            send({cmd_write_status, 8'(c << 2)}, 0);
            wait_idle();
            stat(8'(c << 2));
            for (int a = 1; a < 4; a++) begin
                prot = (c == 3) || (c == 2 && a >= 2) || (c == 1 && a == 3);
                send({cmd_set_write_latch}, 0);
                send({cmd_write_array, 8'(a << 2), 8'h00, 8'h5a}, 0);
                stat(8'(c << 2) | (prot ? 8'h02 : 8'h03));
                if (prot) send({cmd_clear_write_latch}, 0);
                else wait_idle();
            end
        end
        send({cmd_set_write_latch}, 0);
        send({cmd_write_status, 8'h80}, 0);
        wait_idle();
        stat(8'h80);
        @(posedge core_clk) wp_n <= 1'b0;
        send({cmd_set_write_latch}, 0);
        send({cmd_write_status, 8'h00}, 0);
        stat(8'h82);
        send({cmd_write_array, 8'h04, 8'h00, 8'h5a}, 0);
        stat(8'h83);
        wait_idle();
        @(posedge core_clk) wp_n <= 1'b1;
        send({cmd_set_write_latch}, 0);
        send({cmd_write_status, 8'h00}, 0);
        wait_idle();
        stat(8'h00);
        $display("test protect done");
    endtask
    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_latch();
        t_write();
        t_refuse();
        host.idle_hi = 1'b1;
        t_latch();
        t_protect();
        print_verdict();
    end
    initial begin
        repeat (90000) @(posedge core_clk);
        errors++;
        $display("watchdog expired");
        print_verdict();
    end
endmodule
